// ===== logic/irm_mailbox.sv
// master-to-slave request mailbox with an AXI4-Lite port for the master core
//
// How it works
// - control register clears to 00h on reset
// - master reads/writes control; slave reads it and can only clear its valid flag
// - bit 4 enables response-valid interrupt to master
// - valid flag: master sets, slave software clears
// - control bits 7:6 always read zero
// - both data words clear to 0000h on reset
// - data words written by master only
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "irm_regs.svh"

module irm_mailbox
    import irm_pkg::*;
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]    awaddr,
    input  wire logic [2:0]    awprot,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    // axi4-lite write response
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // axi4-lite read
    input  wire logic [7:0]    araddr,
    input  wire logic [2:0]    arprot,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // slave core side, same clock
    input  wire logic          slv_ctl_we,
    input  wire logic [7:0]    slv_ctl_wdata,
    input  wire logic          resp_valid_flag,
    output irm_req_view_s      req_view,
    // interrupt to master core
    output logic               irq
);

    irm_state_s s;
    irm_state_s next_s;
    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic       wr_do;
    logic       mst_set;
    logic       slv_clear;
    logic       ev_resp;
    logic       ev_done;

    // byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0]  strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction : merge16

    // read mux: response code above the data word
    function automatic logic [33:0] rd_word(input logic [5:0] idx,
                                            input irm_state_s st);
        logic [33:0] r;
        r = {`IRM_RESP_OKAY, 32'h0000_0000};
        unique case (idx)
            `IRM_IDX_CTL: begin
                r[5:0] = {st.req.rvf, st.req.rie, st.req.cmd};
            end
            `IRM_IDX_WORD_A: begin
                r[15:0] = st.req.word_a;
            end
            `IRM_IDX_WORD_B: begin
                r[15:0] = st.req.word_b;
            end
            `IRM_IDX_IRQ_STAT: begin
                r[1:0] = st.irq_stat;
            end
            `IRM_IDX_IRQ_MASK: begin
                r[1:0] = st.irq_mask;
            end
            default: begin
                r[33:32] = `IRM_RESP_SLVERR;
            end
        endcase
        return r;
    endfunction : rd_word

    always_comb begin
        next_s    = s;
        aw_fire   = awvalid & s.awready;
        w_fire    = wvalid & s.wready;
        ar_fire   = arvalid & s.arready;
        wr_do     = s.aw_full & s.w_full & ~s.bvalid;
        mst_set   = 1'b0;
        // the slave core has no other write path into the mailbox
        slv_clear = slv_ctl_we & ~slv_ctl_wdata[`IRM_VALID_BIT];
        ev_resp   = resp_valid_flag & ~s.resp_prev & s.req.rie;
        ev_done   = s.req.rvf & slv_clear;

        if (aw_fire) begin
            next_s.aw_full = 1'b1;
            next_s.awaddr  = awaddr;
        end
        if (w_fire) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = wdata;
            next_s.wstrb  = wstrb;
        end

        if (wr_do) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `IRM_RESP_OKAY;
            unique case (s.awaddr[7:2])
                `IRM_IDX_CTL: begin
                    if (s.wstrb[0]) begin
                        next_s.req.cmd = s.wdata[`IRM_CMD_MSB:`IRM_CMD_LSB];
                        next_s.req.rie = s.wdata[`IRM_RIE_BIT];
                        mst_set        = s.wdata[`IRM_VALID_BIT];
                    end
                end
                `IRM_IDX_WORD_A: begin
                    next_s.req.word_a = merge16(s.req.word_a, s.wdata[15:0],
                                                s.wstrb[1:0]);
                end
                `IRM_IDX_WORD_B: begin
                    next_s.req.word_b = merge16(s.req.word_b, s.wdata[15:0],
                                                s.wstrb[1:0]);
                end
                `IRM_IDX_IRQ_STAT: begin
                    if (s.wstrb[0]) begin
                        next_s.irq_stat = s.irq_stat & ~s.wdata[1:0];
                    end
                end
                `IRM_IDX_IRQ_MASK: begin
                    if (s.wstrb[0]) begin
                        next_s.irq_mask = s.wdata[1:0];
                    end
                end
                default: begin
                    next_s.bresp = `IRM_RESP_SLVERR;
                end
            endcase
        end else if (s.bvalid & bready) begin
            next_s.bvalid = 1'b0;
        end

        // a master set in the same cycle as a slave clear wins
        if (mst_set) begin
            next_s.req.rvf = 1'b1;
        end else if (slv_clear) begin
            next_s.req.rvf = 1'b0;
        end

        // events set after the clear so that a new event is never lost
        next_s.irq_stat[`IRM_EV_RESP_BIT] = next_s.irq_stat[`IRM_EV_RESP_BIT] | ev_resp;
        next_s.irq_stat[`IRM_EV_DONE_BIT] = next_s.irq_stat[`IRM_EV_DONE_BIT] | ev_done;
        next_s.irq       = |(next_s.irq_stat & next_s.irq_mask);
        next_s.resp_prev = resp_valid_flag;

        if (ar_fire) begin
            next_s.rvalid                = 1'b1;
            {next_s.rresp, next_s.rdata} = rd_word(araddr[7:2], s);
        end else if (s.rvalid & rready) begin
            next_s.rvalid = 1'b0;
        end

        next_s.awready = ~next_s.aw_full;
        next_s.wready  = ~next_s.w_full;
        next_s.arready = ~next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s                                  <= '0;
            {s.req.rvf, s.req.rie, s.req.cmd} <= `IRM_CTL_RESET;
            s.req.word_a                       <= `IRM_WORD_RESET;
            s.req.word_b                       <= `IRM_WORD_RESET;
            s.irq_stat                         <= `IRM_IRQ_RESET;
            s.irq_mask                         <= `IRM_IRQ_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign awready  = s.awready;
    assign wready   = s.wready;
    assign bresp    = s.bresp;
    assign bvalid   = s.bvalid;
    assign arready  = s.arready;
    assign rdata    = s.rdata;
    assign rresp    = s.rresp;
    assign rvalid   = s.rvalid;
    assign req_view = s.req;
    assign irq      = s.irq;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence mst_ctl_wr_s;
        wr_do && s.awaddr[7:2] == `IRM_IDX_CTL && s.wstrb[0];
    endsequence

    sequence mst_sets_valid_s;
        mst_ctl_wr_s ##0 s.wdata[`IRM_VALID_BIT];
    endsequence

    ctl_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> {s.req.rvf, s.req.rie, s.req.cmd} == `IRM_CTL_RESET)
        else $error("control register not cleared by reset");

    word_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> s.req.word_a == `IRM_WORD_RESET && s.req.word_b == `IRM_WORD_RESET)
        else $error("data words not cleared by reset");

    reserved_zero_a: assert property (
        ar_fire && araddr[7:2] == `IRM_IDX_CTL |=> rvalid && rdata[31:6] == 26'h0)
        else $error("control reserved bits read nonzero");

    slave_readonly_a: assert property (
        !wr_do |=> $stable(s.req.word_a) && $stable(s.req.word_b)
                   && $stable(s.req.cmd) && $stable(s.req.rie))
        else $error("mailbox changed without a master write");

    resp_irq_a: assert property (
        resp_valid_flag && !s.resp_prev && s.req.rie && s.irq_mask[`IRM_EV_RESP_BIT]
        && !(wr_do && s.awaddr[7:2] == `IRM_IDX_IRQ_MASK)
        |=> irq && s.irq_stat[`IRM_EV_RESP_BIT])
        else $error("enabled response flag did not raise interrupt");

    resp_gate_a: assert property (
        !s.req.rie && !s.irq_stat[`IRM_EV_RESP_BIT] && !wr_do
        |=> !s.irq_stat[`IRM_EV_RESP_BIT])
        else $error("response event latched while disabled");

    valid_set_a: assert property (mst_sets_valid_s |=> s.req.rvf)
        else $error("master write of one did not set valid flag");

    valid_hold_a: assert property (
        s.req.rvf && !slv_clear |=> s.req.rvf)
        else $error("valid flag cleared without slave write of zero");

    slave_clear_a: assert property (
        slv_clear && !mst_set |=> !s.req.rvf)
        else $error("slave write of zero did not clear valid flag");

    bvalid_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");

endmodule : irm_mailbox

// ===== shared/irm_regs.svh
// register offsets, field positions and reset values of the request mailbox
`ifndef IRM_REGS_SVH
`define IRM_REGS_SVH
`define IRM_IDX_CTL      6'h0e
`define IRM_IDX_WORD_A   6'h0f
`define IRM_IDX_WORD_B   6'h10
`define IRM_IDX_IRQ_STAT 6'h20
`define IRM_IDX_IRQ_MASK 6'h21
`define IRM_CMD_LSB      0
`define IRM_CMD_MSB      3
`define IRM_RIE_BIT      4
`define IRM_VALID_BIT    5
`define IRM_EV_RESP_BIT  0
`define IRM_EV_DONE_BIT  1
`define IRM_CTL_RESET    6'h00
`define IRM_WORD_RESET   16'h0000
`define IRM_IRQ_RESET    2'h0
`define IRM_RESP_OKAY    2'h0
`define IRM_RESP_SLVERR  2'h2
`endif

// ===== shared/irm_pkg.sv
// types of the inter-core request mailbox
package irm_pkg;
    typedef struct packed {
        logic [3:0]  cmd;
        logic        rie;
        logic        rvf;
        logic [15:0] word_a;
        logic [15:0] word_b;
    } irm_req_view_s;

    typedef struct packed {
        irm_req_view_s req;
        logic [1:0]    irq_stat;
        logic [1:0]    irq_mask;
        logic          irq;
        logic          resp_prev;
        logic          awready;
        logic          wready;
        logic          aw_full;
        logic          w_full;
        logic [7:0]    awaddr;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
    } irm_state_s;
endpackage : irm_pkg

// ===== sim/irm_slave_model.sv
// slave core stand-in: consumes requests and raises its response flag
`timescale 1ns/1ps

module irm_slave_model
    import irm_pkg::*;
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // orders from the bench
    input  wire logic          clear_req,
    input  wire logic          poke_one,
    input  wire logic          resp_set,
    // mailbox side
    input  wire irm_req_view_s req_view,
    output logic               slv_ctl_we,
    output logic [7:0]         slv_ctl_wdata,
    output logic               resp_valid_flag
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slv_ctl_we      <= 1'b0;
            slv_ctl_wdata   <= 8'h00;
            resp_valid_flag <= 1'b0;
        end else begin
            // software clears only a flag it has seen set
            slv_ctl_we      <= (clear_req && req_view.rvf) || poke_one;
            // idle data toggles so a stray sample is never a lucky match
            slv_ctl_wdata   <= poke_one ? 8'h20 : (clear_req ? 8'h00 : ~slv_ctl_wdata);
            resp_valid_flag <= resp_set;
        end
    end
endmodule : irm_slave_model

// ===== sim/irm_mailbox_bench.sv
// self-checking bench of the request mailbox
`timescale 1ns/1ps
`include "irm_regs.svh"

module irm_mailbox_bench;
    import irm_pkg::*;
    localparam logic [7:0] a_ctl = {`IRM_IDX_CTL, 2'b00};
    localparam logic [7:0] a_wa  = {`IRM_IDX_WORD_A, 2'b00};
    localparam logic [7:0] a_wb  = {`IRM_IDX_WORD_B, 2'b00};
    localparam logic [7:0] a_st  = {`IRM_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] a_mk  = {`IRM_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] a_bad = 8'h44;
    localparam logic [1:0] ok    = `IRM_RESP_OKAY;
    localparam logic [1:0] err   = `IRM_RESP_SLVERR;
    logic          aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic          bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic          clear_req = 1'b0, poke_one = 1'b0, resp_set = 1'b0;
    logic [7:0]    awaddr = 8'h00, araddr = 8'h00, slv_ctl_wdata;
    logic [31:0]   wdata = 32'h0, rdata, q;
    logic [3:0]    wstrb = 4'h0;
    logic [1:0]    bresp, rresp, r;
    logic          awready, wready, arready, bvalid, rvalid, irq, slv_ctl_we, resp_valid_flag;
    irm_req_view_s req_view;
    int            miscompares = 0, compares = 0;

    irm_mailbox dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .slv_ctl_we(slv_ctl_we), .slv_ctl_wdata(slv_ctl_wdata),
        .resp_valid_flag(resp_valid_flag), .req_view(req_view), .irq(irq));
    irm_slave_model partner (.aclk(aclk), .aresetn(aresetn), .clear_req(clear_req),
        .poke_one(poke_one), .resp_set(resp_set), .req_view(req_view),
        .slv_ctl_we(slv_ctl_we), .slv_ctl_wdata(slv_ctl_wdata),
        .resp_valid_flag(resp_valid_flag));

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic conclude();
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [37:0] e, input logic [37:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk

    // handshakes are judged at the falling edge, so the rising edge never races
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        logic aw, w, ar, fin;
        fin = 1'b0;
        @(posedge aclk);
        if (wr) begin
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end else begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        repeat (40) begin
            @(negedge aclk);
            aw  = awvalid && awready;
            w   = wvalid && wready;
            ar  = arvalid && arready;
            fin = (bvalid && bready) || (rvalid && rready);
            q   = rdata;
            r   = wr ? bresp : rresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (ar) arvalid <= 1'b0;
            if (fin) begin
                bready <= 1'b0;
                rready <= 1'b0;
                break;
            end
        end
        if (!fin) begin
            miscompares++;
            conclude();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        xfer(1'b1, a, d, s);
        chk("bresp", er, r);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(n, e, q);
        chk("rresp", er, r);
    endtask : rd_chk

    task automatic t_reset();
        rd_chk("control", a_ctl, 32'h0, ok);
        rd_chk("word a", a_wa, 32'h0, ok);
        rd_chk("word b", a_wb, 32'h0, ok);
        rd_chk("irq status", a_st, 32'h0, ok);
        rd_chk("irq mask", a_mk, 32'h0, ok);
        chk("view", 38'h0, req_view);
    endtask : t_reset

    task automatic t_request();
        wr(a_ctl, 32'hffff_ffca, 4'hf, ok);
        rd_chk("control", a_ctl, 32'h0a, ok);
        wr(a_wa, 32'h1234_5678, 4'hf, ok);
        wr(a_wb, 32'h0000_beef, 4'h1, ok);
        rd_chk("word a", a_wa, 32'h5678, ok);
        rd_chk("word b", a_wb, 32'h00ef, ok);
        wr(a_ctl, 32'h3a, 4'h1, ok);
        wr(a_ctl, 32'h1a, 4'h1, ok);
        poke_one <= 1'b1;
        @(posedge aclk);
        poke_one <= 1'b0;
        rd_chk("control", a_ctl, 32'h3a, ok);
        chk("view", {4'ha, 1'b1, 1'b1, 16'h5678, 16'h00ef}, req_view);
        clear_req <= 1'b1;
        @(posedge aclk);
        clear_req <= 1'b0;
        repeat (20) begin
            xfer(1'b0, a_ctl, 32'h0, 4'h0);
            if (q[5] !== 1'b1) break;
        end
        chk("control", 32'h1a, q);
        rd_chk("irq status", a_st, 32'h2, ok);
    endtask : t_request

    task automatic t_irq();
        wr(a_mk, 32'h3, 4'h1, ok);
        @(negedge aclk);
        chk("irq", 1'b1, irq);
        wr(a_st, 32'h2, 4'h1, ok);
        rd_chk("irq status", a_st, 32'h0, ok);
        @(negedge aclk);
        chk("irq", 1'b0, irq);
        @(posedge aclk);
        resp_set <= 1'b1;
        repeat (3) @(negedge aclk);
        chk("irq", 1'b1, irq);
        rd_chk("irq status", a_st, 32'h1, ok);
        wr(a_mk, 32'h0, 4'h1, ok);
        @(negedge aclk);
        chk("irq", 1'b0, irq);
        wr(a_st, 32'h1, 4'h1, ok);
        resp_set <= 1'b0;
        wr(a_ctl, 32'h0a, 4'h1, ok);
        resp_set <= 1'b1;
        // let the rise reach the mailbox before the status is read
        repeat (3) @(posedge aclk);
        rd_chk("irq status", a_st, 32'h0, ok);
    endtask : t_irq

    task automatic t_bad();
        wr(a_bad, 32'h5, 4'hf, err);
        rd_chk("unmapped", a_bad, 32'h0, err);
    endtask : t_bad

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_request();
        t_irq();
        t_bad();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        conclude();
    end
endmodule : irm_mailbox_bench
